/* File: pkg/dpc_pkg.sv */
/*
 * Constants for the display pipe configuration and status block.
 * Assumes one 40 MHz clock and a 32-bit word register port with byte enables.
 */
//
// Function
// - Gamma mode bit picks palette lookup (0) or 10-bit interpolation (1).
// - Interlace field decodes progressive, embedded, vsync shift, field sync, field zero.
// - Interlace field applies at once with pipe off, else at vblank.
// - Embedded-panel interlace makes hardware adjust output timing itself.
// - Self-refresh bit clear refreshes continuously; set updates panel on demand.
// - Planes-off blanks planes at next vblank; clearing resumes at following vblank.
// - Cursor-off blanks cursors at next vblank; clearing restores at following vblank.
// - Refresh association decodes software, progressive big FIFO, interlaced big FIFO.
// - Progressive-to-interlaced association keeps pixel clock, uses vsync shift, no scaling.
// - Colour-correction bit applies coefficients when set, bypasses when clear.
// - Power-mode bit selects first or second M/N set.
// - Colour depth decodes 8, 10, 6 bits; applies at next vblank.
// - Output depth differing from frame buffer depth dithers the stream.
// - Dither enable bit turns dithering on, off by default.
// - Dither type selects spatial (00) or spatio-temporal (01).
// - Three max gamma registers hold 17-bit points, reset 0x10000.
// - Status bits stay set; writing one clears, zero leaves them.
// - Summary output is OR of status bits ANDed with enables.
// - Underrun status sets on pop from empty FIFO; never reaches summary.
// - Sprite B flip-done enable gates its status into the summary.
`default_nettype none

package dpc_pkg;

    localparam int DPC_ADDR_W = 20;
    localparam int DPC_DATA_W = 32;
    localparam int DPC_BE_W = 4;
    localparam int DPC_GMAX_W = 17;
    localparam int DPC_NCH = 3;

    // Register offsets
    localparam logic [19:0] DPC_OFS_CONF = 20'h70008;
    localparam logic [19:0] DPC_OFS_GMAX_R = 20'h70010;
    localparam logic [19:0] DPC_OFS_GMAX_G = 20'h70014;
    localparam logic [19:0] DPC_OFS_GMAX_B = 20'h70018;
    localparam logic [19:0] DPC_OFS_STAT = 20'h70024;

    // Reset values and configuration write mask
    localparam logic [31:0] DPC_CONF_RST = 32'h00000000;
    localparam logic [16:0] DPC_GMAX_RST = 17'h10000;
    localparam logic [31:0] DPC_CONF_WMASK = 32'h01ffc0fc;

    // Configuration fields
    localparam int DPC_B_GAMMA = 24;
    localparam int DPC_B_ILACE = 21;
    localparam int DPC_B_SELF = 20;
    localparam int DPC_B_PLOFF = 19;
    localparam int DPC_B_CUROFF = 18;
    localparam int DPC_B_ASSOC = 16;
    localparam int DPC_B_CSC = 15;
    localparam int DPC_B_MN = 14;
    localparam int DPC_B_BPC = 5;
    localparam int DPC_B_DITH = 4;
    localparam int DPC_B_DTYPE = 2;

    // Status fields
    localparam int DPC_B_UNDER = 31;
    localparam int DPC_B_SBF_EN = 30;
    localparam int DPC_B_SBF = 15;

    // Interlace codes
    localparam logic [2:0] DPC_IL_EMBED = 3'h4;
    localparam logic [2:0] DPC_IL_VSHIFT = 3'h5;
    localparam logic [2:0] DPC_IL_FIELD = 3'h6;
    localparam logic [2:0] DPC_IL_F0 = 3'h7;

    // Association codes
    localparam logic [1:0] DPC_AS_SW = 2'h0;
    localparam logic [1:0] DPC_AS_P2P = 2'h1;
    localparam logic [1:0] DPC_AS_P2I = 2'h2;

    // Colour depth codes
    localparam logic [2:0] DPC_BPC_8 = 3'h0;
    localparam logic [2:0] DPC_BPC_10 = 3'h1;
    localparam logic [2:0] DPC_BPC_6 = 3'h2;

    // Dither type codes
    localparam logic [1:0] DPC_DT_SPATIAL = 2'h0;
    localparam logic [1:0] DPC_DT_TEMPORAL = 2'h1;

endpackage : dpc_pkg

`default_nettype wire

/* File: verilog/dpc_vblank_shadow.sv */
/*
 * Active copy of a vblank-deferred configuration field.
 * Assumes vblank_in is a one-cycle pulse at vertical blank start.
 */
`default_nettype none

module dpc_vblank_shadow #(
    parameter int unsigned W = 1
) (
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic arst_n_in,
    input wire logic clk_en_in,
    // Field
    input wire logic [W-1:0] shadow_in,
    input wire logic vblank_in,
    input wire logic bypass_in,
    output logic [W-1:0] active_out,
    output logic pending_out
);

    logic [W-1:0] active_q;
    logic load;

    assign load = vblank_in | bypass_in;
    assign active_out = active_q;
    assign pending_out = (active_q != shadow_in);

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            active_q <= '0;
        end else if (clk_en_in && load) begin
            active_q <= shadow_in;
        end
    end

endmodule : dpc_vblank_shadow

`default_nettype wire

/* File: verilog/dpc_pipe_config.sv */
/*
 * Display pipe configuration, max gamma points and event status.
 * Assumes synchronous inputs, vblank and event inputs as one-cycle pulses,
 * and a word register port whose reads answer one cycle later.
 */
`default_nettype none

module dpc_pipe_config
    import dpc_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic arst_n_in,
    input wire logic clk_en_in,
    // Register port
    input wire logic [dpc_pkg::DPC_ADDR_W-1:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic [dpc_pkg::DPC_BE_W-1:0] reg_be_in,
    input wire logic [dpc_pkg::DPC_DATA_W-1:0] reg_wdata_in,
    input wire logic reg_rd_in,
    output logic [dpc_pkg::DPC_DATA_W-1:0] reg_rdata_out,
    output logic reg_rvalid_out,
    // Pipe timing and events
    input wire logic pipe_enable_in,
    input wire logic vblank_start_in,
    input wire logic fifo_pop_in,
    input wire logic fifo_empty_in,
    input wire logic sprite_b_flip_done_in,
    input wire logic [2:0] fb_bpc_in,
    // Gamma
    output logic gamma_10bit_out,
    output logic [dpc_pkg::DPC_GMAX_W-1:0] gamma_max_red_out,
    output logic [dpc_pkg::DPC_GMAX_W-1:0] gamma_max_green_out,
    output logic [dpc_pkg::DPC_GMAX_W-1:0] gamma_max_blue_out,
    // Interlace and timing
    output logic progressive_out,
    output logic embedded_auto_adjust_out,
    output logic vsync_shift_prog_out,
    output logic vsync_shift_legacy_out,
    output logic field_indication_out,
    output logic field_zero_only_out,
    output logic self_refresh_out,
    // Plane overrides
    output logic planes_blank_out,
    output logic cursors_blank_out,
    // Refresh association
    output logic sw_refresh_only_out,
    output logic bigfifo_p2p_out,
    output logic bigfifo_p2i_out,
    output logic pixclk_switch_allow_out,
    // Pixel path
    output logic csc_enable_out,
    output logic mn_second_out,
    output logic [2:0] bpc_out,
    output logic dither_on_out,
    output logic dither_temporal_out,
    // Status
    output logic summary_out
);

    ////////////////////////////////////////////////////////////////////////
    // Address decode and byte lanes

    logic [31:0] be_mask;
    logic hit_conf;
    logic hit_stat;
    logic [DPC_NCH-1:0] hit_gmax;
    logic wr_conf;
    logic wr_stat;

    for (genvar i = 0; i < DPC_BE_W; i++) begin : g_lane
        assign be_mask[i*8 +: 8] = {8{reg_be_in[i]}};
    end

    assign hit_conf = (reg_addr_in == DPC_OFS_CONF);
    assign hit_stat = (reg_addr_in == DPC_OFS_STAT);
    assign hit_gmax[0] = (reg_addr_in == DPC_OFS_GMAX_R);
    assign hit_gmax[1] = (reg_addr_in == DPC_OFS_GMAX_G);
    assign hit_gmax[2] = (reg_addr_in == DPC_OFS_GMAX_B);
    assign wr_conf = reg_wr_in & hit_conf;
    assign wr_stat = reg_wr_in & hit_stat;

    ////////////////////////////////////////////////////////////////////////
    // Configuration register, software view

    logic [31:0] conf_q;
    logic [31:0] conf_d;
    logic [31:0] conf_wm;

    assign conf_wm = be_mask & DPC_CONF_WMASK;
    assign conf_d = wr_conf ? ((conf_q & ~conf_wm) | (reg_wdata_in & conf_wm)) : conf_q;

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            conf_q <= DPC_CONF_RST;
        end else if (clk_en_in) begin
            conf_q <= conf_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Vblank-deferred fields

    logic [2:0] ilace_act;
    logic [2:0] bpc_act;
    logic ploff_act;
    logic curoff_act;

    // Pipe off: interlace field follows at once
    dpc_vblank_shadow #(
        .W(3)
    ) u_ilace (
        .ref_clk_in(ref_clk_in),
        .arst_n_in(arst_n_in),
        .clk_en_in(clk_en_in),
        .shadow_in(conf_q[DPC_B_ILACE +: 3]),
        .vblank_in(vblank_start_in),
        .bypass_in(~pipe_enable_in),
        .active_out(ilace_act),
        .pending_out()
    );

    dpc_vblank_shadow #(
        .W(3)
    ) u_bpc (
        .ref_clk_in(ref_clk_in),
        .arst_n_in(arst_n_in),
        .clk_en_in(clk_en_in),
        .shadow_in(conf_q[DPC_B_BPC +: 3]),
        .vblank_in(vblank_start_in),
        .bypass_in(1'b0),
        .active_out(bpc_act),
        .pending_out()
    );

    dpc_vblank_shadow #(
        .W(1)
    ) u_ploff (
        .ref_clk_in(ref_clk_in),
        .arst_n_in(arst_n_in),
        .clk_en_in(clk_en_in),
        .shadow_in(conf_q[DPC_B_PLOFF]),
        .vblank_in(vblank_start_in),
        .bypass_in(1'b0),
        .active_out(ploff_act),
        .pending_out()
    );

    dpc_vblank_shadow #(
        .W(1)
    ) u_curoff (
        .ref_clk_in(ref_clk_in),
        .arst_n_in(arst_n_in),
        .clk_en_in(clk_en_in),
        .shadow_in(conf_q[DPC_B_CUROFF]),
        .vblank_in(vblank_start_in),
        .bypass_in(1'b0),
        .active_out(curoff_act),
        .pending_out()
    );

    ////////////////////////////////////////////////////////////////////////
    // Field decode

    logic [1:0] assoc;
    logic [1:0] dtype;
    logic prog_d;
    logic embed_d;
    logic vs_prog_d;
    logic vs_leg_d;
    logic field_d;
    logic f0_d;
    logic dith_d;

    assign assoc = conf_q[DPC_B_ASSOC +: 2];
    assign dtype = conf_q[DPC_B_DTYPE +: 2];

    assign prog_d = ~ilace_act[2];
    assign embed_d = (ilace_act == DPC_IL_EMBED);
    // Programmable shift for embedded interlace or interlaced association
    assign vs_prog_d = embed_d | (assoc == DPC_AS_P2I);
    assign vs_leg_d = (ilace_act == DPC_IL_VSHIFT) |
                      (ilace_act == DPC_IL_FIELD) |
                      (ilace_act == DPC_IL_F0);
    assign field_d = (ilace_act == DPC_IL_FIELD);
    assign f0_d = (ilace_act == DPC_IL_F0);

    // Enable bit, or depth mismatch against the frame buffer
    assign dith_d = conf_q[DPC_B_DITH] | (bpc_act != fb_bpc_in);

    ////////////////////////////////////////////////////////////////////////
    // Registered control outputs

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            gamma_10bit_out <= 1'b0;
            progressive_out <= 1'b1;
            embedded_auto_adjust_out <= 1'b0;
            vsync_shift_prog_out <= 1'b0;
            vsync_shift_legacy_out <= 1'b0;
            field_indication_out <= 1'b0;
            field_zero_only_out <= 1'b0;
            self_refresh_out <= 1'b0;
            planes_blank_out <= 1'b0;
            cursors_blank_out <= 1'b0;
            sw_refresh_only_out <= 1'b1;
            bigfifo_p2p_out <= 1'b0;
            bigfifo_p2i_out <= 1'b0;
            pixclk_switch_allow_out <= 1'b0;
            csc_enable_out <= 1'b0;
            mn_second_out <= 1'b0;
            bpc_out <= DPC_BPC_8;
            dither_on_out <= 1'b0;
            dither_temporal_out <= 1'b0;
        end else if (clk_en_in) begin
            gamma_10bit_out <= conf_q[DPC_B_GAMMA];
            progressive_out <= prog_d;
            embedded_auto_adjust_out <= embed_d;
            vsync_shift_prog_out <= vs_prog_d;
            vsync_shift_legacy_out <= vs_leg_d;
            field_indication_out <= field_d;
            field_zero_only_out <= f0_d;
            self_refresh_out <= conf_q[DPC_B_SELF];
            planes_blank_out <= ploff_act;
            cursors_blank_out <= curoff_act;
            sw_refresh_only_out <= (assoc == DPC_AS_SW);
            bigfifo_p2p_out <= (assoc == DPC_AS_P2P);
            bigfifo_p2i_out <= (assoc == DPC_AS_P2I);
            // Interlaced association keeps the pixel clock
            pixclk_switch_allow_out <= (assoc == DPC_AS_P2P);
            csc_enable_out <= conf_q[DPC_B_CSC];
            mn_second_out <= conf_q[DPC_B_MN];
            bpc_out <= bpc_act;
            dither_on_out <= dith_d;
            dither_temporal_out <= dith_d & (dtype == DPC_DT_TEMPORAL);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Max gamma points

    logic [DPC_GMAX_W-1:0] gmax_q [DPC_NCH];

    for (genvar c = 0; c < DPC_NCH; c++) begin : g_gmax
        logic [DPC_GMAX_W-1:0] gm;
        logic [DPC_GMAX_W-1:0] gd;

        assign gm = be_mask[DPC_GMAX_W-1:0];
        assign gd = (gmax_q[c] & ~gm) | (reg_wdata_in[DPC_GMAX_W-1:0] & gm);

        always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
            if (!arst_n_in) begin
                gmax_q[c] <= DPC_GMAX_RST;
            end else if (clk_en_in && reg_wr_in && hit_gmax[c]) begin
                gmax_q[c] <= gd;
            end
        end
    end

    assign gamma_max_red_out = gmax_q[0];
    assign gamma_max_green_out = gmax_q[1];
    assign gamma_max_blue_out = gmax_q[2];

    ////////////////////////////////////////////////////////////////////////
    // Event status

    logic under_q;
    logic sbf_q;
    logic sbf_en_q;
    logic under_set;
    logic under_clr;
    logic sbf_clr;
    logic under_d;
    logic sbf_d;
    logic sbf_en_d;

    assign under_set = fifo_pop_in & fifo_empty_in;
    assign under_clr = wr_stat & reg_wdata_in[DPC_B_UNDER] & be_mask[DPC_B_UNDER];
    assign sbf_clr = wr_stat & reg_wdata_in[DPC_B_SBF] & be_mask[DPC_B_SBF];

    // New event beats a clear in the same cycle
    assign under_d = under_set | (under_q & ~under_clr);
    assign sbf_d = sprite_b_flip_done_in | (sbf_q & ~sbf_clr);

    assign sbf_en_d = (wr_stat && be_mask[DPC_B_SBF_EN]) ?
                      reg_wdata_in[DPC_B_SBF_EN] : sbf_en_q;

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            under_q <= 1'b0;
            sbf_q <= 1'b0;
            sbf_en_q <= 1'b0;
            summary_out <= 1'b0;
        end else if (clk_en_in) begin
            under_q <= under_d;
            sbf_q <= sbf_d;
            sbf_en_q <= sbf_en_d;
            // Underrun stays out of the summary
            summary_out <= |{sbf_q & sbf_en_q};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read path

    logic [31:0] stat_rd;
    logic [31:0] gmax_rd;
    logic [31:0] rd_mux;

    always_comb begin
        stat_rd = '0;
        stat_rd[DPC_B_UNDER] = under_q;
        stat_rd[DPC_B_SBF_EN] = sbf_en_q;
        stat_rd[DPC_B_SBF] = sbf_q;
    end

    assign gmax_rd = hit_gmax[0] ? {15'h0000, gmax_q[0]} :
                     hit_gmax[1] ? {15'h0000, gmax_q[1]} :
                     hit_gmax[2] ? {15'h0000, gmax_q[2]} : 32'h00000000;

    // Unmapped offsets read zero
    assign rd_mux = hit_conf ? conf_q :
                    hit_stat ? stat_rd : gmax_rd;

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            reg_rdata_out <= 32'h00000000;
            reg_rvalid_out <= 1'b0;
        end else if (clk_en_in) begin
            reg_rdata_out <= reg_rd_in ? rd_mux : 32'h00000000;
            reg_rvalid_out <= reg_rd_in;
        end
    end

endmodule : dpc_pipe_config

`default_nettype wire

/* File: tb/dpc_pipe_config_properties.sv */
/*
 * Port checker for dpc_pipe_config.
 * Assumes one clock domain; bound to the top module below.
 */
`default_nettype none

module dpc_pipe_config_properties
    import dpc_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic arst_n_in,
    input wire logic clk_en_in,
    // Register port
    input wire logic [dpc_pkg::DPC_ADDR_W-1:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic [dpc_pkg::DPC_BE_W-1:0] reg_be_in,
    input wire logic [dpc_pkg::DPC_DATA_W-1:0] reg_wdata_in,
    // Events
    input wire logic vblank_start_in,
    input wire logic sprite_b_flip_done_in,
    input wire logic [2:0] fb_bpc_in,
    // Outputs
    input wire logic gamma_10bit_out,
    input wire logic planes_blank_out,
    input wire logic cursors_blank_out,
    input wire logic [2:0] bpc_out,
    input wire logic dither_on_out,
    input wire logic sw_refresh_only_out,
    input wire logic bigfifo_p2i_out,
    input wire logic summary_out
);
    timeunit 1ns;
    timeprecision 100ps;

    default clocking @(posedge ref_clk_in);
    endclocking
    default disable iff (!arst_n_in);

    logic conf_wr;
    logic stat_wr;
    assign conf_wr = clk_en_in && reg_wr_in && reg_addr_in == DPC_OFS_CONF;
    assign stat_wr = clk_en_in && reg_wr_in && reg_addr_in == DPC_OFS_STAT;

    ////////////////////////////////////////////////////////////////////////////
    gamma_mode_a: assert property (conf_wr && reg_be_in[3] ##1 clk_en_in
        |=> gamma_10bit_out == $past(reg_wdata_in[DPC_B_GAMMA], 2))
        else $error("gamma mode output does not follow write");
    assoc_decode_a: assert property (conf_wr && reg_be_in[2] ##1 clk_en_in
        |=> sw_refresh_only_out == ($past(reg_wdata_in[17:16], 2) == DPC_AS_SW)
        && bigfifo_p2i_out == ($past(reg_wdata_in[17:16], 2) == DPC_AS_P2I))
        else $error("association decode wrong");
    planes_sync_a: assert property ($changed(planes_blank_out)
        |-> $past(vblank_start_in, 2))
        else $error("planes blank changed outside vblank");
    cursor_sync_a: assert property ($changed(cursors_blank_out)
        |-> $past(vblank_start_in, 2))
        else $error("cursor blank changed outside vblank");
    depth_sync_a: assert property ($changed(bpc_out) |-> $past(vblank_start_in, 2))
        else $error("colour depth changed outside vblank");
    depth_dither_a: assert property ($past(arst_n_in) && $past(clk_en_in)
        && bpc_out != $past(fb_bpc_in) |-> dither_on_out)
        else $error("depth mismatch without dithering");
    flip_summary_a: assert property ($rose(summary_out)
        |-> $past(sprite_b_flip_done_in, 2) || $past(stat_wr && reg_be_in[3], 2))
        else $error("summary rose without cause");
    status_clear_a: assert property (stat_wr && reg_be_in[1] && reg_wdata_in[15]
        && !sprite_b_flip_done_in ##1 clk_en_in |=> !summary_out)
        else $error("summary stayed after clear");

endmodule : dpc_pipe_config_properties

bind dpc_pipe_config dpc_pipe_config_properties u_props (
    .ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in), .clk_en_in(clk_en_in),
    .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in), .reg_be_in(reg_be_in),
    .reg_wdata_in(reg_wdata_in), .vblank_start_in(vblank_start_in),
    .sprite_b_flip_done_in(sprite_b_flip_done_in), .fb_bpc_in(fb_bpc_in),
    .gamma_10bit_out(gamma_10bit_out), .planes_blank_out(planes_blank_out),
    .cursors_blank_out(cursors_blank_out), .bpc_out(bpc_out),
    .dither_on_out(dither_on_out), .sw_refresh_only_out(sw_refresh_only_out),
    .bigfifo_p2i_out(bigfifo_p2i_out), .summary_out(summary_out)
);

`default_nettype wire

/* File: tb/dpc_timing_model.sv */
/*
 * Pipe timing generator stand-in: vblank, flips, pixel FIFO pops.
 * Assumes the bench steers run, flip and starve requests.
 */
`default_nettype none

module dpc_timing_model (
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic arst_n_in,
    // Bench control
    input wire logic run_in,
    input wire logic flip_req_in,
    input wire logic starve_in,
    // Pipe events
    output logic vblank_start_out,
    output logic sprite_b_flip_done_out,
    output logic fifo_pop_out,
    output logic fifo_empty_out
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [3:0] line_q;
    logic frame_end;
    assign frame_end = run_in && line_q == 4'hf;

    // Flip completes only at a frame boundary
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            line_q <= 4'h0;
            vblank_start_out <= 1'b0;
            sprite_b_flip_done_out <= 1'b0;
            fifo_pop_out <= 1'b0;
            fifo_empty_out <= 1'b0;
        end else begin
            line_q <= run_in ? line_q + 4'h1 : 4'h0;
            vblank_start_out <= frame_end;
            sprite_b_flip_done_out <= frame_end && flip_req_in;
            fifo_pop_out <= run_in;
            fifo_empty_out <= starve_in;
        end
    end

endmodule : dpc_timing_model

`default_nettype wire

/* File: tb/dpc_pipe_config_bench.sv */
/*
 * Self-checking bench for dpc_pipe_config.
 * Assumes dpc_timing_model supplies vblank and pipe events.
 */
`default_nettype none

module dpc_pipe_config_bench import dpc_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;

    logic clk, rst_n, en, wr, rd, pipe_en, run, flip, starve;
    logic [19:0] addr;
    logic [3:0] be;
    logic [31:0] wdata, rdata, e;
    logic [2:0] fb_bpc, bpc, il;
    logic [1:0] c;
    logic vb, sbf, pop, empty, rvalid, g10, prog, emb, vsp, vsl, fld, f0, self_r;
    logic pl, cu, sw, p2p, p2i, pix, csc, mn, dith, dtmp, summ;
    logic [16:0] gr, gg, gb;
    logic [1:0] codes [5] = '{2'h1, 2'h0, 2'h2, 2'h0, 2'h3};
    int num_errors = 0;
    int num_checks = 0;

    dpc_pipe_config u_dut (
        .ref_clk_in(clk), .arst_n_in(rst_n), .clk_en_in(en),
        .reg_addr_in(addr), .reg_wr_in(wr), .reg_be_in(be), .reg_wdata_in(wdata),
        .reg_rd_in(rd), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
        .pipe_enable_in(pipe_en), .vblank_start_in(vb), .fifo_pop_in(pop),
        .fifo_empty_in(empty), .sprite_b_flip_done_in(sbf), .fb_bpc_in(fb_bpc),
        .gamma_10bit_out(g10), .gamma_max_red_out(gr), .gamma_max_green_out(gg),
        .gamma_max_blue_out(gb), .progressive_out(prog), .embedded_auto_adjust_out(emb),
        .vsync_shift_prog_out(vsp), .vsync_shift_legacy_out(vsl),
        .field_indication_out(fld), .field_zero_only_out(f0), .self_refresh_out(self_r),
        .planes_blank_out(pl), .cursors_blank_out(cu), .sw_refresh_only_out(sw),
        .bigfifo_p2p_out(p2p), .bigfifo_p2i_out(p2i), .pixclk_switch_allow_out(pix),
        .csc_enable_out(csc), .mn_second_out(mn), .bpc_out(bpc), .dither_on_out(dith),
        .dither_temporal_out(dtmp), .summary_out(summ)
    );

    dpc_timing_model u_model (
        .ref_clk_in(clk), .arst_n_in(rst_n), .run_in(run), .flip_req_in(flip),
        .starve_in(starve), .vblank_start_out(vb), .sprite_b_flip_done_out(sbf),
        .fifo_pop_out(pop), .fifo_empty_out(empty)
    );

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic tick;
        @(posedge clk);
        #1;
    endtask : tick

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr_reg(input logic [19:0] a, input logic [3:0] b, input logic [31:0] d);
        addr = a;
        be = b;
        wdata = d;
        wr = 1'b1;
        tick;
        wr = 1'b0;
        tick;
    endtask : wr_reg

    task automatic rd_chk(input logic [19:0] a, input logic [31:0] exp);
        addr = a;
        rd = 1'b1;
        tick;
        chk(32'(rvalid), 32'h1);
        chk(rdata, exp);
        rd = 1'b0;
        tick;
    endtask : rd_chk

    // Runs frames until one vblank, then lets load and output land
    task automatic wait_vb;
        int n;
        n = 0;
        run = 1'b1;
        while (vb !== 1'b1 && n < 64) begin
            tick;
            n++;
        end
        if (n == 64) begin
            num_errors++;
            finish_test;
        end
        run = 1'b0;
        tick;
        tick;
    endtask : wait_vb

    task automatic done(input string s);
        $display("test %s done", s);
    endtask : done

    task automatic finish_test;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : finish_test

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        rst_n = 1'b0;
        en = 1'b1;
        wr = 1'b0;
        rd = 1'b0;
        addr = 20'h0;
        be = 4'h0;
        wdata = 32'h0;
        pipe_en = 1'b0;
        run = 1'b0;
        flip = 1'b0;
        starve = 1'b0;
        fb_bpc = 3'h0;
        repeat (10) @(posedge clk);
        #1;
        rst_n = 1'b1;
        chk(32'({prog, sw, dith, gr, bpc}), 32'({2'h3, 1'b0, DPC_GMAX_RST, 3'h0}));
        rd_chk(DPC_OFS_GMAX_B, 32'h0001_0000);
        rd_chk(DPC_OFS_CONF, 32'h0);
        rd_chk(DPC_OFS_STAT, 32'h0);
        rd_chk(20'h7001c, 32'h0);
        done("reset");
        wr_reg(DPC_OFS_GMAX_R, 4'hf, 32'hfffe_abcd);
        wr_reg(DPC_OFS_GMAX_G, 4'h4, 32'h0);
        wr_reg(DPC_OFS_GMAX_G, 4'h1, 32'h77);
        rd_chk(DPC_OFS_GMAX_R, 32'h0000_abcd);
        rd_chk(DPC_OFS_GMAX_G, 32'h0000_0077);
        chk(32'({gr, gg}), 32'({17'habcd, 17'h77}));
        chk(32'(gb), 32'h0001_0000);
        en = 1'b0;
        wr_reg(DPC_OFS_GMAX_B, 4'hf, 32'h0000_1234);
        en = 1'b1;
        rd_chk(DPC_OFS_GMAX_B, 32'h0001_0000);
        done("gamma points");
        for (int i = 0; i < 5; i++) begin
            c = codes[i];
            wr_reg(DPC_OFS_CONF, 4'hf, 32'h0110_c000 | {14'h0, c, 16'h0});
            e = 32'({4'hf, c == 2'h0, c == 2'h1, c == 2'h2, c == 2'h1, c == 2'h2});
            chk(32'({g10, self_r, csc, mn, sw, p2p, p2i, pix, vsp}), e);
        end
        wr_reg(DPC_OFS_CONF, 4'hf, 32'h8100_c0ff);
        rd_chk(DPC_OFS_CONF, 32'h0100_c0fc);
        done("immediate fields");
        for (int i = 0; i < 8; i++) begin
            il = 3'(i);
            wr_reg(DPC_OFS_CONF, 4'hf, {8'h0, il, 21'h0});
            tick;
            e = 32'({!il[2], il == 3'h4, il == 3'h4, il > 3'h4, il == 3'h6, il == 3'h7});
            chk(32'({g10, self_r, csc, mn, prog, emb, vsp, vsl, fld, f0}), e);
        end
        wr_reg(DPC_OFS_CONF, 4'hf, 32'h0);
        tick;
        done("interlace decode");
        pipe_en = 1'b1;
        wr_reg(DPC_OFS_CONF, 4'hf, 32'h00cc_0040);
        repeat (4) tick;
        chk(32'({fld, pl, cu, bpc, dith, dtmp}), 32'h0);
        wait_vb;
        chk(32'({fld, pl, cu, bpc, dith, dtmp}), 32'hea);
        wr_reg(DPC_OFS_CONF, 4'hf, 32'h0000_0014);
        chk(32'({pl, cu, dith, dtmp}), 32'hf);
        wait_vb;
        chk(32'({fld, pl, cu, bpc, dith, dtmp}), 32'h03);
        wr_reg(DPC_OFS_CONF, 4'hf, 32'h0000_0010);
        chk(32'({dith, dtmp}), 32'h2);
        fb_bpc = 3'h1;
        wr_reg(DPC_OFS_CONF, 4'hf, 32'h0);
        chk(32'(dith), 32'h1);
        fb_bpc = 3'h0;
        tick;
        chk(32'(dith), 32'h0);
        done("vblank deferred");
        wr_reg(DPC_OFS_STAT, 4'hf, 32'h4000_0000);
        flip = 1'b1;
        wait_vb;
        flip = 1'b0;
        chk(32'(summ), 32'h1);
        wr_reg(DPC_OFS_STAT, 4'h8, 32'h0);
        tick;
        chk(32'(summ), 32'h0);
        starve = 1'b1;
        run = 1'b1;
        repeat (3) tick;
        starve = 1'b0;
        run = 1'b0;
        rd_chk(DPC_OFS_STAT, 32'h8000_8000);
        wr_reg(DPC_OFS_STAT, 4'hc, 32'h4000_0000);
        tick;
        chk(32'(summ), 32'h1);
        wr_reg(DPC_OFS_STAT, 4'h3, 32'h0);
        rd_chk(DPC_OFS_STAT, 32'hc000_8000);
        wr_reg(DPC_OFS_STAT, 4'hf, 32'h4000_8000);
        tick;
        chk(32'(summ), 32'h0);
        rd_chk(DPC_OFS_STAT, 32'hc000_0000);
        wr_reg(DPC_OFS_STAT, 4'hf, 32'hc000_0000);
        rd_chk(DPC_OFS_STAT, 32'h4000_0000);
        done("status");
        finish_test;
    end

endmodule : dpc_pipe_config_bench

`default_nettype wire
